// ==== src/mcdc_pkg.sv ====
// Constants, carriers and helpers for the modulator clock and decimation control block.
// Assumes a single main clock that also clocks the register bus.
package mcdc_pkg;

   // ==================================================================
   // Register bus
   localparam int             AW            = 5;
   localparam int             DW            = 32;
   localparam logic [AW-1:0]  OFS_CTRL      = 5'h00;
   localparam logic [AW-1:0]  OFS_BAND      = 5'h04;
   localparam logic [AW-1:0]  OFS_STATUS    = 5'h08;
   localparam logic [AW-1:0]  OFS_DATA0     = 5'h0C;
   localparam logic [AW-1:0]  OFS_DATA1     = 5'h10;
   localparam logic [AW-1:0]  OFS_DATA2     = 5'h14;

   typedef struct packed {
      logic [AW-1:0] address;
      logic          read;
      logic          write;
      logic [DW-1:0] writedata;
   } mcdc_avm_req_s;

   // ==================================================================
   // Control fields and reset values
   localparam int             CTRL_PWR_LSB  = 0;
   localparam int             CTRL_DIV_LSB  = 2;
   localparam int             CTRL_OSR_LSB  = 4;
   localparam int             CTRL_TURBO    = 7;
   localparam int             CTRL_STBY     = 8;
   localparam int             PWR_HR_BIT    = 1;
   localparam logic [1:0]     PWR_RST       = 2'h2;
   localparam logic [1:0]     DIV_RST       = 2'h0;
   localparam logic [2:0]     OSR_RST       = 3'h3;
   localparam logic [3:0]     BAND_RST      = 4'h8;
   localparam int             STAT_SINC3    = 0;
   localparam int             STAT_STBY     = 1;
   localparam int             STAT_CONV_LSB = 2;
   localparam int             STAT_BAND_OK  = 4;
   localparam int             STAT_SEQ_LSB  = 8;

   // ==================================================================
   // Datapath sizes and ratios
   localparam int             NCH           = 3;
   localparam int             OUT_W         = 17;
   localparam int             ACC_W         = 35;
   localparam int             CNT_W         = 14;
   localparam int             FULL_LOG      = 16;
   localparam logic [3:0]     OSR_LOG_TURBO = 4'd6;
   localparam logic [3:0]     OSR_LOG_BASE  = 4'd7;
   localparam logic [3:0]     SINC3_LOG_MAX = 4'd10;
   localparam logic [1:0]     FAST_CONVS    = 2'd2;
   localparam int             BAND_HI_KHZ   = 4100;
   localparam int             BAND_LO_KHZ [16] = '{3768, 3366, 3041, 2773, 2549, 2358, 2194,
                                                  2051, 1926, 1815, 1716, 1627, 1547, 1475,
                                                  1409, 1400};

   typedef logic [OUT_W-1:0] mcdc_sample_t;

   // Divider ratio for a divider field value
   function automatic logic [3:0] mcdc_ndiv(input logic [1:0] sel);
      unique case (sel)
         2'b00: mcdc_ndiv = 4'd2;
         2'b01: mcdc_ndiv = 4'd4;
         2'b10: mcdc_ndiv = 4'd8;
         2'b11: mcdc_ndiv = 4'd12;
      endcase
   endfunction : mcdc_ndiv

   // Band code for a modulator rate in kHz; bands run from fast to slow
   function automatic logic [3:0] mcdc_band(input int khz);
      mcdc_band = 4'hF;
      for (int i = 15; i >= 0; i--) begin
         if (khz >= BAND_LO_KHZ[i]) begin
            mcdc_band = 4'(i);
         end
      end
   endfunction : mcdc_band

endpackage : mcdc_pkg

// ==== src/mcdc_clock_decim.sv ====
// Modulator clock divider, power mode and band code holding, and a three channel
// decimation filter with fast-settling and sinc3 (+ sinc1) paths.
// Assumes ref_clk is the continuously running main clock and all inputs are synchronous.
`timescale 1ns/1ps

module mcdc_clock_decim
   import mcdc_pkg::*;
#(
   parameter int MAIN_CLK_KHZ = 10000
) (
   input  wire  logic                          ref_clk,
   input  wire  logic                          nrst,
   input  wire  mcdc_pkg::mcdc_avm_req_s       avm_req,
   output logic [mcdc_pkg::DW-1:0]             avm_readdata,
   output logic                                avm_waitrequest,
   input  wire  logic [mcdc_pkg::NCH-1:0]      mod_bits,
   output logic                                modulator_clock,
   output logic                                high_resolution_mode,
   output logic                                low_power_mode,
   output logic [3:0]                          supply_sync_band_code,
   output logic                                sample_valid,
   output mcdc_pkg::mcdc_sample_t [mcdc_pkg::NCH-1:0] sample_data
);
   import mcdc_pkg::*;

   // ==================================================================
   // Declarations
   logic [1:0]          power_mode_sel_r;
   logic [1:0]          clk_div_sel_r;
   logic [2:0]          decimation_ratio_sel_r;
   logic                turbo_r;
   logic                standby_r;
   logic [3:0]          band_code_r;
   logic                ack_r;
   logic                wr_go;
   logic [2:0]          div_cnt_r;
   logic [2:0]          half_m1;
   logic                mod_en;
   logic [3:0]          osr_log;
   logic [3:0]          k3;
   logic [3:0]          k1;
   logic [CNT_W-1:0]    osr_mask;
   logic [CNT_W-1:0]    s3_mask;
   logic [CNT_W-1:0]    dec_cnt_r;
   logic                s3_tick;
   logic                first_grp;
   logic                last_smp;
   logic [ACC_W-1:0]    int1_r [NCH];
   logic [ACC_W-1:0]    int2_r [NCH];
   logic [ACC_W-1:0]    int3_r [NCH];
   logic [ACC_W-1:0]    dl1_r  [NCH];
   logic [ACC_W-1:0]    dl2_r  [NCH];
   logic [ACC_W-1:0]    dl3_r  [NCH];
   logic [ACC_W-1:0]    s1_r   [NCH];
   logic [ACC_W-1:0]    c1     [NCH];
   logic [ACC_W-1:0]    c2     [NCH];
   logic [ACC_W-1:0]    c3     [NCH];
   logic [ACC_W-1:0]    s1_nxt [NCH];
   logic [ACC_W-1:0]    fast_r [NCH];
   logic [ACC_W-1:0]    fast_nxt [NCH];
   logic [1:0]          conv_cnt_r;
   logic                use_sinc3;
   logic [7:0]          seq_r;
   logic [5:0]          sh3;
   logic [5:0]          shf;
   int                  fmod_khz;
   logic [3:0]          band_expect;
   logic                band_in_range;

   // ==================================================================
   // Avalon slave: one wait cycle, then the answer
   assign avm_waitrequest = (avm_req.read | avm_req.write) & ~ack_r;
   assign wr_go           = avm_req.write & ack_r;

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= (avm_req.read | avm_req.write) & ~ack_r;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         avm_readdata <= '0;
      end else if (avm_req.read && !ack_r) begin
         avm_readdata <= '0;
         unique case (avm_req.address)
            OFS_CTRL: begin
               avm_readdata[CTRL_PWR_LSB +: 2] <= power_mode_sel_r;
               avm_readdata[CTRL_DIV_LSB +: 2] <= clk_div_sel_r;
               avm_readdata[CTRL_OSR_LSB +: 3] <= decimation_ratio_sel_r;
               avm_readdata[CTRL_TURBO]        <= turbo_r;
               avm_readdata[CTRL_STBY]         <= standby_r;
            end
            OFS_BAND:   avm_readdata[3:0] <= band_code_r;
            OFS_STATUS: begin
               avm_readdata[STAT_SINC3]          <= use_sinc3;
               avm_readdata[STAT_STBY]           <= standby_r;
               avm_readdata[STAT_CONV_LSB +: 2]  <= conv_cnt_r;
               avm_readdata[STAT_BAND_OK]        <= band_in_range &&
                                                    (band_expect == band_code_r);
               avm_readdata[STAT_SEQ_LSB +: 8]   <= seq_r;
            end
            OFS_DATA0:  avm_readdata[OUT_W-1:0] <= sample_data[0];
            OFS_DATA1:  avm_readdata[OUT_W-1:0] <= sample_data[1];
            OFS_DATA2:  avm_readdata[OUT_W-1:0] <= sample_data[2];
            default:    avm_readdata <= '0;
         endcase
      end
   end

   // ==================================================================
   // Control registers
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         power_mode_sel_r       <= PWR_RST;
         clk_div_sel_r          <= DIV_RST;
         decimation_ratio_sel_r <= OSR_RST;
         turbo_r                <= 1'b0;
         standby_r              <= 1'b0;
      end else if (wr_go && avm_req.address == OFS_CTRL) begin
         power_mode_sel_r       <= avm_req.writedata[CTRL_PWR_LSB +: 2];
         clk_div_sel_r          <= avm_req.writedata[CTRL_DIV_LSB +: 2];
         // Ratio taken as written
         // Not gated by standby; a change while converting corrupts data and, with the count past the new ratio, delays the strobe until the count wraps
         decimation_ratio_sel_r <= avm_req.writedata[CTRL_OSR_LSB +: 3];
         turbo_r                <= avm_req.writedata[CTRL_TURBO];
         standby_r              <= avm_req.writedata[CTRL_STBY];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         band_code_r <= BAND_RST;
      end else if (wr_go && avm_req.address == OFS_BAND) begin
         band_code_r <= avm_req.writedata[3:0];
      end
   end
   assign supply_sync_band_code = band_code_r;

   assign high_resolution_mode = power_mode_sel_r[PWR_HR_BIT];
   assign low_power_mode       = ~power_mode_sel_r[PWR_HR_BIT];

   assign fmod_khz      = MAIN_CLK_KHZ / int'(mcdc_ndiv(clk_div_sel_r));
   assign band_expect   = mcdc_band(fmod_khz);
   assign band_in_range = (fmod_khz <= BAND_HI_KHZ) && (fmod_khz >= BAND_LO_KHZ[15]);

   // ==================================================================
   // Modulator clock divider
   // Ratio decode, half period count
   assign half_m1 = 3'(mcdc_ndiv(clk_div_sel_r) >> 1) - 3'd1;
   // One modulator tick per ratio count of main clocks
   assign mod_en  = (div_cnt_r >= half_m1) & ~modulator_clock;

   // Toggle every half ratio for an even duty cycle
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         div_cnt_r       <= '0;
         modulator_clock <= 1'b0;
      end else if (div_cnt_r >= half_m1) begin
         div_cnt_r       <= '0;
         modulator_clock <= ~modulator_clock;
      end else begin
         div_cnt_r       <= div_cnt_r + 3'd1;
      end
   end

   // ==================================================================
   // Ratio decode
   // Turbo forces 64; otherwise 128 up to 16384
   assign osr_log  = turbo_r ? OSR_LOG_TURBO : OSR_LOG_BASE + {1'b0, decimation_ratio_sel_r};
   // Split into sinc3 and sinc1 shares
   assign k3       = (osr_log > SINC3_LOG_MAX) ? SINC3_LOG_MAX : osr_log;
   assign k1       = osr_log - k3;
   assign osr_mask = CNT_W'((32'd1 << osr_log) - 32'd1);
   assign s3_mask  = CNT_W'((32'd1 << k3) - 32'd1);
   assign s3_tick  = mod_en && ((dec_cnt_r & s3_mask) == s3_mask);
   assign first_grp = (dec_cnt_r >> k3) == '0;
   assign last_smp = dec_cnt_r == osr_mask;
   assign sh3      = 6'd3 * {2'b00, k3} + {2'b00, k1} - 6'(FULL_LOG);
   assign shf      = 6'(FULL_LOG) - {2'b00, osr_log};

   // ==================================================================
   // Filter combs and accumulators
   always_comb begin
      for (int ch = 0; ch < NCH; ch++) begin
         c1[ch]       = int3_r[ch] - dl1_r[ch];
         c2[ch]       = c1[ch] - dl2_r[ch];
         c3[ch]       = c2[ch] - dl3_r[ch];
         // Sinc1 sums sinc3 outputs over the remaining factor
         s1_nxt[ch]   = (first_grp ? '0 : s1_r[ch]) + c3[ch];
         // Fast-settling path counts ones in parallel
         fast_nxt[ch] = (dec_cnt_r == '0 ? '0 : fast_r[ch]) + ACC_W'(mod_bits[ch]);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst || standby_r) begin
         dec_cnt_r <= '0;
      end else if (mod_en) begin
         // Decimation count wraps at the ratio
         dec_cnt_r <= last_smp ? '0 : dec_cnt_r + CNT_W'(1);
      end
   end

   always_ff @(posedge ref_clk) begin
      for (int ch = 0; ch < NCH; ch++) begin
         if (!nrst || standby_r) begin
            int1_r[ch] <= '0;
            int2_r[ch] <= '0;
            int3_r[ch] <= '0;
            dl1_r[ch]  <= '0;
            dl2_r[ch]  <= '0;
            dl3_r[ch]  <= '0;
            s1_r[ch]   <= '0;
            fast_r[ch] <= '0;
         end else if (mod_en) begin
            int1_r[ch] <= int1_r[ch] + ACC_W'(mod_bits[ch]);
            int2_r[ch] <= int2_r[ch] + int1_r[ch];
            int3_r[ch] <= int3_r[ch] + int2_r[ch];
            fast_r[ch] <= fast_nxt[ch];
            if (s3_tick) begin
               dl1_r[ch] <= int3_r[ch];
               dl2_r[ch] <= c1[ch];
               dl3_r[ch] <= c2[ch];
               s1_r[ch]  <= s1_nxt[ch];
            end
         end
      end
   end

   // ==================================================================
   // Output selection and strobe
   // Fast path until two conversions are out
   assign use_sinc3 = conv_cnt_r == FAST_CONVS;

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         sample_valid <= 1'b0;
         sample_data  <= '0;
         conv_cnt_r   <= '0;
         seq_r        <= '0;
      end else begin
         sample_valid <= 1'b0;
         if (mod_en && last_smp && !standby_r) begin
            sample_valid <= 1'b1;
            seq_r        <= seq_r + 8'd1;
            if (!use_sinc3) begin
               conv_cnt_r <= conv_cnt_r + 2'd1;
            end
            // Both paths scaled so an all-ones stream reads 2^16
            for (int ch = 0; ch < NCH; ch++) begin
               sample_data[ch] <= use_sinc3 ? OUT_W'(s1_nxt[ch] >> sh3)
                                            : OUT_W'(fast_nxt[ch] << shf);
            end
         end
      end
   end

   // ==================================================================
   // Checks and their helper counters
   logic [3:0]  gap_r;
   logic        gap_ok_r;
   logic [1:0]  div_prev_r;
   logic [14:0] mods_r;
   logic        osr_ok_r;
   logic [3:0]  osr_prev_r;

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         gap_r      <= '0;
         gap_ok_r   <= 1'b0;
         div_prev_r <= DIV_RST;
         mods_r     <= '0;
         osr_ok_r   <= 1'b0;
         osr_prev_r <= '0;
      end else begin
         div_prev_r <= clk_div_sel_r;
         osr_prev_r <= osr_log;
         gap_r      <= mod_en ? 4'd1 : gap_r + 4'd1;
         if (clk_div_sel_r != div_prev_r) begin
            gap_ok_r <= 1'b0;
         end else if (mod_en) begin
            gap_ok_r <= 1'b1;
         end
         if (sample_valid || standby_r) begin
            mods_r <= '0;
         end else if (mod_en) begin
            mods_r <= mods_r + 15'd1;
         end
         if (standby_r || osr_log != osr_prev_r || clk_div_sel_r != div_prev_r) begin
            osr_ok_r <= 1'b0;
         end else if (sample_valid) begin
            osr_ok_r <= 1'b1;
         end
      end
   end

   a_div_ratio_period: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      mod_en && gap_ok_r && clk_div_sel_r == div_prev_r |-> gap_r == mcdc_ndiv(clk_div_sel_r))
      else $error("modulator tick spacing differs from divider ratio");

   a_div2_even_duty: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      clk_div_sel_r == 2'b00 && $stable(clk_div_sel_r) && $past(clk_div_sel_r) == 2'b00
      |=> modulator_clock != $past(modulator_clock))
      else $error("divide by two clock does not toggle every cycle");

   a_tick_on_rise: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      mod_en |=> $rose(modulator_clock))
      else $error("modulator tick not aligned to clock rise");

   a_power_mode_excl: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      high_resolution_mode == power_mode_sel_r[PWR_HR_BIT] && high_resolution_mode != low_power_mode)
      else $error("power mode outputs inconsistent");

   a_band_code_8: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      fmod_khz >= 1926 && fmod_khz < 2051 |-> band_expect == 4'h8)
      else $error("band code for 1.926-2.051 MHz is not 8");

   a_ratio_samples: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      sample_valid && osr_ok_r |-> mods_r == 15'(32'd1 << osr_log))
      else $error("sample spacing differs from oversampling ratio");

   a_ratio_decode: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      !turbo_r |-> {18'h0, osr_mask} + 32'd1 == (32'd128 << decimation_ratio_sel_r))
      else $error("ratio field decode wrong");

   a_turbo_ratio: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      turbo_r |-> osr_mask == 14'h003F)
      else $error("turbo ratio is not 64");

   a_sinc1_split: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      osr_log > 4'd10 |-> s3_mask == 14'h03FF && k1 == osr_log - 4'd10 && k1 <= 4'd4)
      else $error("sinc3 and sinc1 ratio split wrong");

   a_fast_then_sinc3: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      $rose(use_sinc3) |-> sample_valid && seq_r == 8'd2)
      else $error("switch to sinc3 path not after two conversions");

   a_valid_single: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      sample_valid |=> !sample_valid [*3])
      else $error("output strobe longer than one cycle");

   a_bus_one_wait: assert property (
      @(posedge ref_clk) disable iff (!nrst)
      $rose(avm_req.read | avm_req.write) |-> avm_waitrequest ##1 !avm_waitrequest)
      else $error("bus answer not after one wait cycle");

endmodule : mcdc_clock_decim

// ==== verif/mcdc_mod_source.sv ====
// Modulator bitstream source standing in for the three isolated modulators.
// Assumes it shares ref_clk with the block and watches the block's modulator clock.
`timescale 1ns/1ps
module mcdc_mod_source
   import mcdc_pkg::*;
(
   input  wire  logic                ref_clk,
   input  wire  logic                modulator_clock,
   output logic [mcdc_pkg::NCH-1:0]  mod_bits
);
   import mcdc_pkg::*;
   logic mclk_q = 1'b0;
   logic alt_r  = 1'b0;
   // ==================================================================
   // Bitstream
   // One bit per tick
   always_ff @(posedge ref_clk) begin
      mclk_q <= modulator_clock;
      if (modulator_clock && !mclk_q) begin
         alt_r <= ~alt_r;
      end
   end
   // Full, empty and half density keep every expected average exact
   assign mod_bits = {alt_r, 1'b0, 1'b1};
endmodule : mcdc_mod_source

// ==== verif/mcdc_clock_decim_bench.sv ====
// Self-checking bench for the modulator clock and decimation control block.
// Assumes the bitstream source model and the design package are compiled first.
`timescale 1ns/1ps
module mcdc_clock_decim_bench;
   import mcdc_pkg::*;
   logic                   ref_clk = 1'b0;
   logic                   nrst    = 1'b0;
   mcdc_avm_req_s          avm_req = '0;
   logic [DW-1:0]          avm_readdata;
   logic                   avm_waitrequest;
   logic [NCH-1:0]         mod_bits;
   logic                   modulator_clock;
   logic                   high_resolution_mode;
   logic                   low_power_mode;
   logic [3:0]             supply_sync_band_code;
   logic                   sample_valid;
   mcdc_sample_t [NCH-1:0] sample_data;
   logic [DW-1:0]          rd;
   int                     fails     = 0;
   int                     tests_run = 0;
   int                     n, hi, lo, gap, lg;
   logic [1:0]             dv_tab [4] = '{2'h1, 2'h1, 2'h0, 2'h2};
   logic [3:0]             bd_tab [4] = '{4'h8, 4'h7, 4'h0, 4'hF};
   logic [DW-1:0]          ok_tab [4] = '{32'h0000_0010, 32'h0, 32'h0000_0010, 32'h0};
   int                     nd_tab [4] = '{2, 4, 8, 12};

   // ==================================================================
   // Clock and instances
   // Free running main clock
   initial begin
      forever #50 ref_clk = ~ref_clk;
   end
   mcdc_clock_decim #(.MAIN_CLK_KHZ(8192)) i_mcdc_clock_decim (
      .ref_clk(ref_clk), .nrst(nrst), .avm_req(avm_req), .avm_readdata(avm_readdata),
      .avm_waitrequest(avm_waitrequest), .mod_bits(mod_bits),
      .modulator_clock(modulator_clock), .high_resolution_mode(high_resolution_mode),
      .low_power_mode(low_power_mode), .supply_sync_band_code(supply_sync_band_code),
      .sample_valid(sample_valid), .sample_data(sample_data));
   mcdc_mod_source i_mcdc_mod_source (
      .ref_clk(ref_clk), .modulator_clock(modulator_clock), .mod_bits(mod_bits));

   // ==================================================================
   // Tasks
   task automatic results;
      $display("Checks run %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : results
   task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic hang;
      check(32'h0, 32'h1);
      results();
   endtask : hang
   // Request held until waitrequest is seen low at a falling edge
   task automatic bus(input logic wr, input logic [AW-1:0] a, input logic [DW-1:0] d);
      logic w = 1'b1;
      int   k = 0;
      @(posedge ref_clk);
      avm_req.address   <= a;
      avm_req.writedata <= d;
      avm_req.write     <= wr;
      avm_req.read      <= !wr;
      while (w) begin
         @(negedge ref_clk);
         w  = (avm_waitrequest !== 1'b0);
         rd = avm_readdata;
         @(posedge ref_clk);
         k++;
         if (k > 20) hang();
      end
      avm_req.write <= 1'b0;
      avm_req.read  <= 1'b0;
   endtask : bus
   task automatic rdchk(input logic [AW-1:0] a, input logic [DW-1:0] m, input logic [DW-1:0] e);
      bus(1'b0, a, 32'h0);
      check(rd & m, e);
   endtask : rdchk
   function automatic logic [DW-1:0] ctl(input logic [1:0] p, input logic [1:0] dv,
                                         input logic [2:0] s, input logic t, input logic sb);
      return {23'h0, sb, t, s, dv, p};
   endfunction : ctl
   task automatic run_until(input logic v, output int c);
      c = 0;
      do begin
         @(negedge ref_clk);
         c++;
      end while (modulator_clock !== v && c < 100);
      if (c >= 100) hang();
   endtask : run_until
   task automatic wait_valid(output int c);
      c = 0;
      do begin
         @(negedge ref_clk);
         c++;
      end while (sample_valid !== 1'b1 && c < 40000);
      if (c >= 40000) hang();
   endtask : wait_valid

   // ==================================================================
   // Sequence
   initial begin
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
      rdchk(OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_0032);
      rdchk(OFS_BAND, 32'hFFFF_FFFF, 32'h0000_0008);
      rdchk(5'h18, 32'hFFFF_FFFF, 32'h0);
      check(32'({high_resolution_mode, low_power_mode}), 32'h0000_0002);
      check(32'(supply_sync_band_code), 32'h0000_0008);
      bus(1'b1, OFS_CTRL, ctl(2'h1, 2'h0, 3'h3, 1'b0, 1'b0));
      // Outputs settle after the write edge
      @(negedge ref_clk);
      check(32'({high_resolution_mode, low_power_mode}), 32'h0000_0001);
      // Band code written by the host
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, OFS_BAND, {28'h0, bd_tab[i]});
         bus(1'b1, OFS_CTRL, ctl(2'h2, dv_tab[i], 3'h3, 1'b0, 1'b0));
         rdchk(OFS_STATUS, 32'h0000_0010, ok_tab[i]);
         check(32'(supply_sync_band_code), 32'(bd_tab[i]));
      end
      $display("Test band codes done");
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, OFS_CTRL, ctl(2'h2, 2'(i), 3'h3, 1'b0, 1'b0));
         // First period after a change may be stretched, so skip two
         repeat (2) begin
            run_until(1'b0, n);
            run_until(1'b1, n);
         end
         run_until(1'b0, hi);
         run_until(1'b1, lo);
         check(32'(hi), 32'(nd_tab[i] / 2));
         check(32'(lo), 32'(nd_tab[i] / 2));
      end
      $display("Test clock divider done");
      @(posedge ref_clk);
      nrst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
      rdchk(OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_0032);
      for (int i = 0; i < 6; i++) begin
         lg = (i == 0) ? 6 : 6 + i;
         bus(1'b1, OFS_CTRL, ctl(2'h2, 2'h0, 3'((i == 0) ? 0 : i - 1), i == 0, 1'b1));
         rdchk(OFS_STATUS, 32'h0000_0002, 32'h0000_0002);
         bus(1'b1, OFS_CTRL, ctl(2'h2, 2'h0, 3'((i == 0) ? 0 : i - 1), i == 0, 1'b0));
         for (int k = 1; k <= 5; k++) begin
            wait_valid(gap);
            if (k == 5) check(32'(gap), 32'(2 << lg));
            if (k == 5 || (i == 0 && k < 3)) begin
               check(32'(sample_data[0]), 32'h0001_0000);
               check(32'(sample_data[1]), 32'h0);
               check(32'(sample_data[2]), 32'h0000_8000);
            end
            if (k == 1 && i == 0) rdchk(OFS_STATUS, 32'h0000_000F, 32'h0000_0004);
            if (k == 3) rdchk(OFS_STATUS, 32'h0000_000F, 32'h0000_0009);
         end
         rdchk(OFS_DATA2, 32'hFFFF_FFFF, 32'h0000_8000);
         $display("Test ratio step %0d done", i);
      end
      results();
   end
endmodule : mcdc_clock_decim_bench
